// File: xpst_pkg.sv
// Package for the channel pattern self-test block: modes, widths, carriers.
// Assumes one parallel clock per channel shared by generator and verifier.
package xpst_pkg;

  // Parallel word width of the channel datapath
  localparam int XPST_W = 10;

  // Pattern selection
  typedef enum logic [2:0]
  {
    XPST_OFF,
    XPST_INCR,
    XPST_PRBS,
    XPST_HIFREQ,
    XPST_LOFREQ
  } xpst_mode_t;

  // Alternating ones and zeros, one word
  localparam logic [XPST_W-1:0] XPST_HF_WORD = 10'h155;
  // Five ones then five zeros, one word
  localparam logic [XPST_W-1:0] XPST_LF_WORD = 10'h3e0;
  // Seed of the pseudo-random register
  localparam logic [6:0] XPST_PRBS_SEED = 7'h7f;
  // Tap positions of the x^7 + x^6 + 1 polynomial
  localparam int XPST_TAP_A = 6;
  localparam int XPST_TAP_B = 5;
  // Words checked before the done flag rises
  localparam logic [15:0] XPST_DONE_CNT = 16'h00ff;

  // Receive-side status bundle
  typedef struct packed
  {
    logic done;   // Enough words compared
    logic error;  // Sticky mismatch seen
    logic locked; // Verifier aligned to stream
  } xpst_stat_t;

endpackage : xpst_pkg

// File: xpst_self_test.sv
// Per-channel pattern generator and verifier for a serial transceiver.
// Assumes the channel is in basic mode while a test runs, and that the
// serializer, deserializer and coding paths share i_clk.
// Behaviour
// - Each channel has own generator and verifier
// - Incrementing data looped back before serializer
// - Random sequence drives serializer, checked at deserializer
// - High frequency pattern alternates ones, zeros
// - Low frequency pattern: five ones, five zeros
// - No checker for high or low patterns
`timescale 1ns/10ps
module xpst_self_test
#(
  parameter int W = xpst_pkg::XPST_W // Parallel word width
)
(
  input  wire logic                 i_clk,        // Channel parallel clock
  input  wire logic                 i_reset,      // Synchronous reset
  input  wire xpst_pkg::xpst_mode_t i_mode,       // Selected pattern
  input  wire logic [W-1:0]         i_user_tx,    // Normal transmit word
  input  wire logic [W-1:0]         i_coded_rx,   // Word after decode path
  input  wire logic [W-1:0]         i_deser_rx,   // Word from deserializer
  output logic      [W-1:0]         o_coder_tx,   // Word into coding path
  output logic      [W-1:0]         o_ser_tx,     // Word to serializer
  output logic                      o_loopback,   // Parallel loop enable
  output xpst_pkg::xpst_stat_t      o_status      // Verifier status
);

  // Generator and verifier state
  logic [W-1:0] incr_cnt;  // Incrementing data
  logic [6:0]   prbs_tx;   // Transmit random register
  logic [6:0]   prbs_rx;   // Receive expected register
  logic [W-1:0] incr_exp;  // Expected incrementing word
  logic [15:0]  chk_cnt;   // Words compared
  logic         mode_chk;  // A checked pattern selected
  logic         mismatch;  // Current word differs
  logic [W-1:0] rx_word;   // Word under test
  logic [W-1:0] exp_word;  // Expected word
  xpst_pkg::xpst_mode_t mode_q; // Previous mode
  logic         st_locked; // Verifier aligned to stream
  logic         st_error;  // Sticky mismatch seen
  logic         st_done;   // Enough words compared

  // One driver for the status port; fields pack as done, error, locked
  assign o_status = {st_done, st_error, st_locked};

  // Step a random register W bits forward
  function automatic logic [6:0] prbs_step(input logic [6:0] s);
    logic [6:0] r;
    r = s;
    for (int i = 0; i < W; i++)
    begin
      r = {r[5:0], r[xpst_pkg::XPST_TAP_A] ^ r[xpst_pkg::XPST_TAP_B]};
    end
    return r;
  endfunction : prbs_step

  // Words from a random register, MSB first
  function automatic logic [W-1:0] prbs_word(input logic [6:0] s);
    logic [6:0]   r;
    logic [W-1:0] w;
    r = s;
    w = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      w[i] = r[xpst_pkg::XPST_TAP_A] ^ r[xpst_pkg::XPST_TAP_B];
      r = {r[5:0], w[i]};
    end
    return w;
  endfunction : prbs_word

  // Incrementing generator, runs only in its mode
  always_ff @(posedge i_clk)
  begin
    if (i_reset || i_mode != xpst_pkg::XPST_INCR)
      incr_cnt <= '0;
    else
      incr_cnt <= incr_cnt + 1'b1;
  end

  // Transmit random generator
  always_ff @(posedge i_clk)
  begin
    if (i_reset || i_mode != xpst_pkg::XPST_PRBS)
      prbs_tx <= xpst_pkg::XPST_PRBS_SEED;
    else
      prbs_tx <= prbs_step(prbs_tx);
  end

  // Coding path input: incrementing data or user data
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_coder_tx <= '0;
    else if (i_mode == xpst_pkg::XPST_INCR)
      o_coder_tx <= incr_cnt;
    else
      o_coder_tx <= i_user_tx;
  end

  // Serializer input: random and fixed patterns bypass coding, incrementing data does not
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_ser_tx <= '0;
    else
    begin
      case (i_mode)
        xpst_pkg::XPST_PRBS:   o_ser_tx <= prbs_word(prbs_tx);
        xpst_pkg::XPST_HIFREQ: o_ser_tx <= xpst_pkg::XPST_HF_WORD;
        xpst_pkg::XPST_LOFREQ: o_ser_tx <= xpst_pkg::XPST_LF_WORD;
        default:               o_ser_tx <= o_coder_tx;
      endcase
    end
  end

  // Parallel loop ahead of serializer in incrementing mode
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_loopback <= 1'b0;
    else
      o_loopback <= (i_mode == xpst_pkg::XPST_INCR);
  end

  // Only incrementing and random modes have a checker
  assign mode_chk = (i_mode == xpst_pkg::XPST_INCR) ||
                    (i_mode == xpst_pkg::XPST_PRBS);

  // Select word under test and expectation
  always_comb
  begin
    rx_word  = i_coded_rx;
    exp_word = incr_exp;
    if (i_mode == xpst_pkg::XPST_PRBS)
    begin
      rx_word  = i_deser_rx;
      exp_word = prbs_word(prbs_rx);
    end
  end
  assign mismatch = mode_chk && o_status.locked && (rx_word != exp_word);

  // Mode history to restart checking on a change
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      mode_q <= xpst_pkg::XPST_OFF;
    else
      mode_q <= i_mode;
  end

  // Verifier expectation: realigns until a word matches, then regenerates.
  // The random expectation waits on its seed word, so lock can take up to
  // one sequence period when the far end started elsewhere.
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !mode_chk || mode_q != i_mode)
    begin
      incr_exp <= '0;
      prbs_rx  <= xpst_pkg::XPST_PRBS_SEED;
    end
    else if (!st_locked)
    begin
      incr_exp <= i_coded_rx + 1'b1;         // Follow received data
      if (rx_word == exp_word)
        prbs_rx <= prbs_step(prbs_rx);       // Aligned, start stepping
    end
    else
    begin
      incr_exp <= incr_exp + 1'b1;
      prbs_rx  <= prbs_step(prbs_rx);
    end
  end

  // Lock once a received word matches the expectation; loop latency makes
  // the first returned words stale, so a fixed lock cycle would misfire
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !mode_chk || mode_q != i_mode)
      st_locked <= 1'b0;
    else if (rx_word == exp_word)
      st_locked <= 1'b1;
  end

  // Sticky error flag
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !mode_chk || mode_q != i_mode)
      st_error <= 1'b0;
    else if (mismatch)
      st_error <= 1'b1;
  end

  // Compared-word counter and done flag
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !mode_chk || mode_q != i_mode)
    begin
      chk_cnt        <= '0;
      st_done        <= 1'b0;
    end
    else if (o_status.locked && chk_cnt != xpst_pkg::XPST_DONE_CNT)
      chk_cnt <= chk_cnt + 1'b1;
    else if (chk_cnt == xpst_pkg::XPST_DONE_CNT)
      st_done <= 1'b1;
  end

  // High frequency pattern, without a checker, clears error and lock one cycle after selection
  a_no_check_hf: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode == xpst_pkg::XPST_HIFREQ) [*2] |-> !o_status.error && !o_status.locked)
    else $error("status active in high frequency mode");
  a_hf_pattern: assert property (@(posedge i_clk) disable iff (i_reset)
    i_mode == xpst_pkg::XPST_HIFREQ |=> o_ser_tx == xpst_pkg::XPST_HF_WORD)
    else $error("high frequency word wrong");
  a_lf_pattern: assert property (@(posedge i_clk) disable iff (i_reset)
    i_mode == xpst_pkg::XPST_LOFREQ |=> o_ser_tx == xpst_pkg::XPST_LF_WORD)
    else $error("low frequency word wrong");
  a_incr_steps: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode == xpst_pkg::XPST_INCR) [*3] |-> o_coder_tx == $past(o_coder_tx) + 1'b1)
    else $error("incrementing data did not step");
  a_loop_follows: assert property (@(posedge i_clk) disable iff (i_reset)
    ##1 o_loopback == ($past(i_mode) == xpst_pkg::XPST_INCR))
    else $error("loopback enable wrong");
  a_prbs_moves: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode == xpst_pkg::XPST_PRBS) [*2] |-> o_ser_tx == prbs_word($past(prbs_tx)))
    else $error("random word not on serializer");
  a_error_sticky: assert property (@(posedge i_clk) disable iff (i_reset)
    o_status.error && $stable(i_mode) && mode_chk |=> o_status.error)
    else $error("error flag dropped");
  a_error_cause: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_status.error) |-> $past(mismatch))
    else $error("error without mismatch");

endmodule : xpst_self_test

// File: xpst_far_model.sv
// Far-side model: coding return path and serializer/deserializer loop.
// Assumes the shared parallel clock; i_flip corrupts returned words.
`timescale 1ns/10ps
module xpst_far_model
(
  input  wire logic       i_clk,      // Parallel clock
  input  wire logic       i_flip,     // Corrupt returned words
  input  wire logic [9:0] i_coder_tx, // Word from coding path
  input  wire logic [9:0] i_ser_tx,   // Word to serializer
  output logic      [9:0] o_coded_rx, // Decoded return word
  output logic      [9:0] o_deser_rx  // Deserialized word
);
  // One-cycle loop delay on both return paths
  always_ff @(posedge i_clk)
  begin
    o_coded_rx <= i_coder_tx ^ {9'h000, i_flip};
    o_deser_rx <= i_ser_tx ^ {9'h000, i_flip};
  end
endmodule : xpst_far_model

// File: xpst_self_test_tb.sv
// Testbench for the channel pattern self-test block.
// Assumes the far model loops both transmit words back.
`timescale 1ns/10ps
module xpst_self_test_tb;
  logic                 i_clk = 1'b0;    // Parallel clock
  logic                 i_reset = 1'b1;  // Sync reset
  logic                 flip = 1'b0;     // Error injection
  xpst_pkg::xpst_mode_t i_mode = xpst_pkg::XPST_OFF; // Pattern
  logic [9:0]           user_tx = 10'h000; // Normal word
  logic [9:0]           coded_rx;        // Loopback return
  logic [9:0]           deser_rx;        // Serial return
  logic [9:0]           coder_tx;        // Coding path word
  logic [9:0]           ser_tx;          // Serializer word
  logic                 loopback;        // Loop enable
  xpst_pkg::xpst_stat_t stat;            // Verifier status
  int                   n_errors = 0;    // Mismatches
  int                   n_checks = 0;    // Comparisons
  // Clock, 5 ns period
  initial forever #2.5 i_clk = ~i_clk;
  xpst_self_test u_xpst_self_test (.i_clk(i_clk), .i_reset(i_reset), .i_mode(i_mode),
    .i_user_tx(user_tx), .i_coded_rx(coded_rx), .i_deser_rx(deser_rx),
    .o_coder_tx(coder_tx), .o_ser_tx(ser_tx), .o_loopback(loopback), .o_status(stat));
  xpst_far_model u_xpst_far_model (.i_clk(i_clk), .i_flip(flip), .i_coder_tx(coder_tx),
    .i_ser_tx(ser_tx), .o_coded_rx(coded_rx), .o_deser_rx(deser_rx));
  // Expected serializer word n of the x^7+x^6+1 sequence, MSB first
  function automatic logic [9:0] ref_prbs(input int n);
    logic [6:0] s;
    logic [9:0] w;
    s = xpst_pkg::XPST_PRBS_SEED;
    w = 10'h000;
    for (int k = 0; k <= n; k++)
    begin
      for (int b = 0; b < 10; b++)
      begin
        w = {w[8:0], s[6] ^ s[5]};
        s = {s[5:0], s[6] ^ s[5]};
      end
    end
    return w;
  endfunction : ref_prbs
  // Compare and count
  task check(input string nm, input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : check
  // Step past an edge so its updates land
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Verdict and end of run
  task print_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // Bounded wait for one status bit
  task wait_stat(input int idx);
    int k;
    for (k = 0; k < 400 && stat[idx] !== 1'b1; k++)
      tick(1);
    if (k == 400)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_stat
  // One corrupted word, then sticky error
  task inject;
    @(posedge i_clk) flip <= 1'b1;
    @(posedge i_clk) flip <= 1'b0;
    tick(4);
    check("error", {9'h000, stat.error}, 10'h001);
    tick(3);
    check("sticky", {9'h000, stat.error}, 10'h001);
  endtask : inject
  // Incrementing data through the parallel loop
  task run_incr;
    @(posedge i_clk) i_mode <= xpst_pkg::XPST_INCR;
    tick(1);
    check("loopback", {9'h000, loopback}, 10'h001);
    check("first", coder_tx, 10'h000);
    tick(1);
    check("second", coder_tx, 10'h001);
    wait_stat(2);
    check("incr status", {7'h00, stat}, 10'h005);
    inject();
  endtask : run_incr
  // Random sequence at the serializer
  task run_prbs;
    @(posedge i_clk) i_mode <= xpst_pkg::XPST_PRBS;
    tick(1);
    check("loop off", {9'h000, loopback}, 10'h000);
    check("prbs word 0", ser_tx, ref_prbs(0));
    tick(1);
    check("prbs word 1", ser_tx, ref_prbs(1));
    wait_stat(0);
    wait_stat(2);
    check("prbs error", {9'h000, stat.error}, 10'h000);
    inject();
  endtask : run_prbs
  // Fixed patterns, transmit only
  task run_fixed(input xpst_pkg::xpst_mode_t m, input logic [9:0] w);
    @(posedge i_clk) i_mode <= m;
    tick(2);
    repeat (3)
    begin
      check("pattern", ser_tx, w);
      check("no checker", {7'h00, stat}, 10'h000);
      tick(1);
    end
  endtask : run_fixed
  // Main sequence
  initial
  begin
    tick(20);
    check("reset", {7'h00, stat}, 10'h000);
    @(posedge i_clk) i_reset <= 1'b0;
    user_tx <= 10'h2a5;
    tick(3);
    check("off path", ser_tx, 10'h2a5);
    run_incr();
    run_prbs();
    run_fixed(xpst_pkg::XPST_HIFREQ, 10'h155);
    run_fixed(xpst_pkg::XPST_LOFREQ, 10'h3e0);
    print_verdict();
  end
endmodule : xpst_self_test_tb
